// [hdl/pcc_config.sv]
// The address map and register access over AHB-Lite were chosen for this implementation.
`timescale 1ns/1ps
`default_nettype none
module pcc_config #(
   parameter logic [7:0]  REVISION_LEVEL   = 8'h01,  // Arbitrary value
   parameter logic [15:0] SUBSYS_DEV_IDENT = 16'h0001,  // Arbitrary value
   parameter logic [15:0] SUBSYS_MAKER_IDENT = 16'h0001,  // Arbitrary value
   parameter bit          COMMON_CLOCK     = 1'b1,
   parameter bit          AER_ENABLE       = 1'b0,
   parameter bit          ECRC_CHECK       = 1'b0,
   parameter bit          ECRC_GEN         = 1'b0,
   parameter logic [7:0]  PORT_NUMBER      = 8'h00,
   parameter int          TAGS             = 16,
   parameter int          LANES            = 1,
   parameter int          MSI_REQUESTED    = 4,
   parameter bit          MSI_ADDR64       = 1'b1,
   parameter bit          NATIVE_ENDPOINT  = 1'b1
) (
   // Clock and reset
   input  wire logic        hclk,
   input  wire logic        hresetn,
   // AHB-Lite slave
   input  wire logic        hsel,
   input  wire logic [7:0]  haddr,
   input  wire logic [1:0]  htrans,
   input  wire logic        hwrite,
   input  wire logic [2:0]  hsize,
   input  wire logic        hready,
   input  wire logic [31:0] hwdata,
   output logic [31:0]      hrdata,
   output logic             hreadyout,
   output logic             hresp,
   // Application side
   output logic [15:0]      cfg_devcsr,
   output logic [8:0]       tags_outstanding,
   output logic             tag_error
);

   // Illegal builds are refused at elaboration
   if (SUBSYS_MAKER_IDENT == 16'hffff)
   begin : g_bad_maker
      $error("subsystem maker ident may not be all ones");
   end

   if (!(TAGS inside {4, 8, 16, 32, 64, 128, 256}))
   begin : g_bad_tags
      $error("unsupported tag count");
   end

   if (TAGS > pcc_pkg::MAX_TAGS)
   begin : g_big_tags
      $error("tag count beyond the tracking store");
   end

   if (LANES == 8 && TAGS > pcc_pkg::NARROW_TAG_LIMIT)
   begin : g_bad_x8
      $error("eight-lane build supports at most 32 tags");
   end

   if (ECRC_CHECK && !AER_ENABLE)
   begin : g_bad_check
      $error("end-to-end CRC check needs advanced error reporting");
   end

   if (ECRC_GEN && !AER_ENABLE)
   begin : g_bad_gen
      $error("end-to-end CRC generation needs advanced error reporting");
   end

   if (!(MSI_REQUESTED inside {1, 2, 4, 8, 16, 32}))
   begin : g_bad_msi
      $error("unsupported message count");
   end

   // Capable field holds log2 of the message count
   function automatic logic [2:0] msi_field(input int count);
      logic [2:0] code;
      code = 3'h0;
      for (int i = 0; i < 6; i++)
      begin
         if (count == (1 << i))
            code = 3'(i);
      end
      return code;
   endfunction : msi_field

   localparam logic [2:0] MMC          = msi_field(MSI_REQUESTED);
   localparam bit         EXT_TAG_CAP  = (TAGS > pcc_pkg::NARROW_TAG_LIMIT);
   localparam bit         MSI_WIDE     = MSI_ADDR64 || NATIVE_ENDPOINT;
   localparam bit         CHECK_CAP    = AER_ENABLE && ECRC_CHECK;
   localparam bit         GEN_CAP      = AER_ENABLE && ECRC_GEN;
   localparam logic [8:0] TAG_COUNT    = 9'(TAGS);
   localparam logic [8:0] NARROW_COUNT = 9'(pcc_pkg::NARROW_TAG_LIMIT);

   // Every field after reset; the slave is ready even while held in reset
   function automatic pcc_pkg::pcc_state_t reset_state();
      pcc_pkg::pcc_state_t s;
      s.pend     = 1'b0;
      s.addr     = 8'h00;
      s.write    = 1'b0;
      s.devctl   = pcc_pkg::DEVCTL_RESET;
      s.busy     = '0;
      s.busy_cnt = 9'h000;
      s.tag_err  = 1'b0;
      s.rdata    = 32'h0;
      s.ready    = 1'b1;
      s.resp     = 1'b0;
      return s;
   endfunction : reset_state

   localparam pcc_pkg::pcc_state_t ST_RESET = reset_state();

   // Read view of every register; unmapped offsets and the command port read zero
   function automatic logic [31:0] rd_value(
      input logic [7:0]  addr,
      input logic [15:0] devctl,
      input logic [8:0]  busy_cnt,
      input logic        tag_err
   );
      logic [31:0] v;
      v = 32'h0;
      unique case (addr)
         pcc_pkg::ADDR_IDENT:
         begin
            v[31:16] = SUBSYS_DEV_IDENT;
            v[15:0]  = SUBSYS_MAKER_IDENT;
         end
         pcc_pkg::ADDR_REVISION:
         begin
            v[7:0] = REVISION_LEVEL;
         end
         pcc_pkg::ADDR_LINK:
         begin
            v[pcc_pkg::LINK_PORT_LSB +: 8] = PORT_NUMBER;
            v[pcc_pkg::LINK_SLOTCLK_BIT]   = COMMON_CLOCK;
         end
         pcc_pkg::ADDR_AER:
         begin
            // Whole structure reads zero when absent
            v[pcc_pkg::AER_PRESENT_BIT] = AER_ENABLE;
            v[pcc_pkg::AER_CHK_BIT]     = CHECK_CAP;
            v[pcc_pkg::AER_GEN_BIT]     = GEN_CAP;
         end
         pcc_pkg::ADDR_DEVCAP:
         begin
            v[pcc_pkg::DEVCAP_EXTTAG_BIT] = EXT_TAG_CAP;
         end
         pcc_pkg::ADDR_DEVCTL:
         begin
            v[15:0] = devctl;
         end
         pcc_pkg::ADDR_MSI:
         begin
            v[pcc_pkg::MSI_MMC_LSB +: 3] = MMC;
            v[pcc_pkg::MSI_64_BIT]       = MSI_WIDE;
         end
         pcc_pkg::ADDR_TAGSTAT:
         begin
            v[8:0]                      = busy_cnt;
            v[pcc_pkg::TAGSTAT_ERR_BIT] = tag_err;
         end
         default:
         begin
            v = 32'h0;
         end
      endcase
      return v;
   endfunction : rd_value

   // Slots beyond the configured count are never tracked
   logic [pcc_pkg::MAX_TAGS-1:0] slot_live;
   for (genvar g = 0; g < pcc_pkg::MAX_TAGS; g++)
   begin : g_slot
      assign slot_live[g] = (g < TAGS);
   end

   // Bus decode
   logic        addr_phase;
   logic        wr_active;
   logic        wr_devctl;
   logic        wr_tagcmd;

   // Tag command decode
   logic [7:0]  cmd_tag;
   logic        cmd_issue;
   logic        cmd_done;
   logic        cmd_clear;
   logic        tag_busy;
   logic        tag_beyond;
   logic        tag_wide_off;
   logic        done_ok;
   logic        issue_ok;
   logic        issue_bad;

   // State
   pcc_pkg::pcc_state_t st_reg;
   pcc_pkg::pcc_state_t st_next;

   // Only whole-word transfers are taken; others complete with no effect
   always_comb
   begin
      addr_phase = hsel && hready && htrans == pcc_pkg::HTRANS_NONSEQ && hsize == pcc_pkg::HSIZE_WORD;
      wr_active  = st_reg.pend && st_reg.write;
      wr_devctl  = wr_active && st_reg.addr == pcc_pkg::ADDR_DEVCTL;
      wr_tagcmd  = wr_active && st_reg.addr == pcc_pkg::ADDR_TAGCMD;
   end

   always_comb
   begin
      cmd_tag      = hwdata[7:0];
      cmd_issue    = hwdata[pcc_pkg::TAGCMD_ISSUE_BIT];
      cmd_done     = hwdata[pcc_pkg::TAGCMD_DONE_BIT];
      cmd_clear    = hwdata[pcc_pkg::TAGCMD_CLEAR_BIT];
      tag_busy     = st_reg.busy[cmd_tag];
      tag_beyond   = {1'b0, cmd_tag} >= TAG_COUNT;
      // Wide tags only once software has opened them up
      tag_wide_off = {1'b0, cmd_tag} >= NARROW_COUNT && !st_reg.devctl[pcc_pkg::DEVCTL_EXTTAG_BIT];
   end

   always_comb
   begin
      // Completion wins when both bits are set and the tag is in flight
      done_ok   = wr_tagcmd && cmd_done && tag_busy;
      issue_ok  = wr_tagcmd && cmd_issue && !done_ok && !tag_beyond && !tag_busy && !tag_wide_off;
      issue_bad = wr_tagcmd && cmd_issue && !done_ok && (tag_beyond || tag_busy || tag_wide_off);
   end

   always_comb
   begin
      st_next       = st_reg;
      st_next.pend  = 1'b0;
      st_next.ready = 1'b1;
      st_next.resp  = 1'b0;

      // Read-only offsets have no write path, so writes there are dropped with OKAY
      if (wr_devctl)
      begin
         st_next.devctl = hwdata[15:0];
      end

      if (done_ok)
      begin
         st_next.busy[cmd_tag] = 1'b0;
      end
      if (issue_ok)
      begin
         st_next.busy[cmd_tag] = 1'b1;
      end
      st_next.busy = st_next.busy & slot_live;
      unique case ({issue_ok, done_ok})
         2'b10:
         begin
            st_next.busy_cnt = st_reg.busy_cnt + 9'h1;
         end
         2'b01:
         begin
            st_next.busy_cnt = st_reg.busy_cnt - 9'h1;
         end
         default:
         begin
            st_next.busy_cnt = st_reg.busy_cnt;
         end
      endcase

      // Clear before set, so an error raised by the same write is kept
      if (wr_tagcmd && cmd_clear)
      begin
         st_next.tag_err = 1'b0;
      end
      if (issue_bad)
      begin
         st_next.tag_err = 1'b1;
      end

      if (addr_phase)
      begin
         st_next.pend  = 1'b1;
         st_next.addr  = haddr;
         st_next.write = hwrite;
      end
      // Built from the updated state, so a write just before is already seen
      if (addr_phase && !hwrite)
      begin
         st_next.rdata = rd_value(haddr, st_next.devctl, st_next.busy_cnt, st_next.tag_err);
      end
   end

   always_ff @(posedge hclk or negedge hresetn)
   begin
      if (!hresetn)
      begin
         st_reg <= ST_RESET;
      end
      else
      begin
         st_reg <= st_next;
      end
   end

   assign hrdata           = st_reg.rdata;
   assign hreadyout        = st_reg.ready;
   assign hresp            = st_reg.resp;
   assign cfg_devcsr       = st_reg.devctl;
   assign tags_outstanding = st_reg.busy_cnt;
   assign tag_error        = st_reg.tag_err;
endmodule : pcc_config
`default_nettype wire

// [hdl/pcc_pkg.sv]
// Behaviour
// - Revision level register is 8 bits, read-only, fixed by a parameter.
// - Subsystem device ident is 16 bits, read-only, fixed by a parameter.
// - Subsystem maker ident is 16 bits, read-only, parameter-set, never all ones.
// - Common-clock option fixes the read-only slot clock bit in link status.
// - Advanced error capability exists only when its option is enabled.
// - CRC check option sets check-capable bit; needs advanced error reporting.
// - CRC generation option sets generation-capable bit; needs advanced error reporting.
// - Link capabilities port number is an 8-bit read-only build value.
// - Supported tag count is 4, 8, 16, 32, 64, 128 or 256.
// - Transaction layer tracks every outstanding completion up to the tag count.
// - Tag count above 32 sets the extended tag supported capability bit.
// - Tags above 31 need extended tag enable; bit exported as control bit 8.
// - Eight-lane variant supports at most 32 tags.
// - Requested interrupt message count sets the multiple message capable field.
// - Build option sets 64-bit address capability in message control.
package pcc_pkg;
   localparam logic [7:0] ADDR_IDENT    = 8'h00;
   localparam logic [7:0] ADDR_REVISION = 8'h04;
   localparam logic [7:0] ADDR_LINK     = 8'h08;
   localparam logic [7:0] ADDR_AER      = 8'h0c;
   localparam logic [7:0] ADDR_DEVCAP   = 8'h10;
   localparam logic [7:0] ADDR_DEVCTL   = 8'h14;
   localparam logic [7:0] ADDR_MSI      = 8'h18;
   localparam logic [7:0] ADDR_TAGCMD   = 8'h1c;
   localparam logic [7:0] ADDR_TAGSTAT  = 8'h20;
   localparam int LINK_SLOTCLK_BIT   = 12;
   localparam int AER_PRESENT_BIT    = 0;
   localparam int AER_CHK_BIT        = 7;
   localparam int AER_GEN_BIT        = 5;
   localparam int DEVCAP_EXTTAG_BIT  = 5;
   localparam int DEVCTL_EXTTAG_BIT  = 8;
   localparam int MSI_64_BIT         = 7;
   localparam int MSI_MMC_LSB        = 1;
   localparam int MAX_TAGS           = 256;
   localparam int NARROW_TAG_LIMIT   = 32;
   localparam int LINK_PORT_LSB      = 24;
   localparam int TAGCMD_ISSUE_BIT   = 8;
   localparam int TAGCMD_DONE_BIT    = 9;
   localparam int TAGCMD_CLEAR_BIT   = 31;
   localparam int TAGSTAT_ERR_BIT    = 9;
   localparam logic [2:0]  HSIZE_WORD = 3'h2;
   localparam logic [15:0] DEVCTL_RESET = 16'h0000;
   localparam logic [1:0]  HTRANS_NONSEQ = 2'h2;

   typedef struct packed {
      logic        pend;
      logic [7:0]  addr;
      logic        write;
      logic [15:0] devctl;
      logic [MAX_TAGS-1:0] busy;
      logic [8:0]  busy_cnt;
      logic        tag_err;
      logic [31:0] rdata;
      logic        ready;
      logic        resp;
   } pcc_state_t;
endpackage : pcc_pkg

// [testbench/pcc_host.sv]
`timescale 1ns/1ps
`default_nettype none
module pcc_host (
   // Bus
   input  wire logic        hclk,
   input  wire logic        hready,
   output var  logic        hsel,
   output var  logic [7:0]  haddr,
   output var  logic [1:0]  htrans,
   output var  logic        hwrite,
   output var  logic [2:0]  hsize,
   output var  logic [31:0] hwdata,
   output var  logic        tmo
);
   initial {hsel, haddr, htrans, hwrite, hsize, hwdata, tmo} = '0;
   // Bounded so a stuck slave ends the run
   task automatic wt;
      for (int n = 0; n < 9; n++)
      begin
         @(posedge hclk);
         if (hready)
            break;
      end
      if (!hready)
         tmo <= 1'b1;
   endtask : wt
   task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d);
      @(posedge hclk);
      {hsel, haddr, htrans, hwrite, hsize} <= {1'b1, a, pcc_pkg::HTRANS_NONSEQ, w, pcc_pkg::HSIZE_WORD};
      wt();
      {hsel, htrans, hwdata} <= {1'b0, 2'h0, d};
      wt();
      hwdata <= ~d;
   endtask : xfer
endmodule : pcc_host
`default_nettype wire

// [testbench/pcc_config_assertions.sv]
`timescale 1ns/1ps
`default_nettype none
module pcc_config_assertions #(parameter int TAGS = 16, parameter logic [7:0] REVISION_LEVEL = 8'h01) (
   // Bus
   input wire logic        hclk,
   input wire logic        hresetn,
   input wire logic        hsel,
   input wire logic [7:0]  haddr,
   input wire logic [1:0]  htrans,
   input wire logic        hwrite,
   input wire logic        hready,
   input wire logic [31:0] hrdata,
   input wire logic        hreadyout,
   input wire logic        hresp,
   // Application
   input wire logic [15:0] cfg_devcsr,
   input wire logic [8:0]  tags_outstanding,
   input wire logic        tag_error
);
   logic ap;
   logic wd;
   assign ap = hsel && hready && htrans == pcc_pkg::HTRANS_NONSEQ;
   always_ff @(posedge hclk or negedge hresetn)
      wd <= !hresetn ? 1'b0 : ap && hwrite;
   default clocking @(posedge hclk); endclocking
   default disable iff (!hresetn);
   AST_READY: assert property (hreadyout) else $error("stall");
   AST_RESP: assert property (!hresp) else $error("error response");
   AST_REV: assert property (ap && !hwrite && haddr == pcc_pkg::ADDR_REVISION |=> hrdata == {24'h0, REVISION_LEVEL})
      else $error("revision");
   AST_MAKER: assert property (ap && !hwrite && haddr == pcc_pkg::ADDR_IDENT |=> hrdata[15:0] != 16'hffff)
      else $error("maker");
   AST_EXT: assert property (ap && !hwrite && haddr == pcc_pkg::ADDR_DEVCAP |=>
      hrdata[pcc_pkg::DEVCAP_EXTTAG_BIT] == (TAGS > pcc_pkg::NARROW_TAG_LIMIT))
      else $error("ext tag");
   AST_TAGS: assert property (tags_outstanding <= TAGS) else $error("count");
   AST_STEP: assert property (!$stable(tags_outstanding) |-> $past(wd)) else $error("count step");
   AST_CSR: assert property (!$stable(cfg_devcsr) |-> $past(wd)) else $error("csr");
   AST_ERR: assert property (tag_error && !wd |=> tag_error) else $error("sticky");
   cover property (tag_error);
   cover property (tags_outstanding == 9'h2);
   cover property ($rose(cfg_devcsr[8]));
endmodule : pcc_config_assertions
bind pcc_config pcc_config_assertions #(.TAGS(TAGS), .REVISION_LEVEL(REVISION_LEVEL)) pcc_config_assertions_inst (
   .hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hready, .hrdata, .hreadyout, .hresp, .cfg_devcsr, .tags_outstanding,
   .tag_error);
`default_nettype wire

// [testbench/pcc_config_tb.sv]
`timescale 1ns/1ps
`default_nettype none
module pcc_config_tb;
   logic        hclk = 1'b0;
   logic        hresetn = 1'b0;
   logic        rdp = 1'b0;
   logic        hsel, hwrite, hreadyout, hresp, tag_error, tmo;
   logic [1:0]  htrans;
   logic [2:0]  hsize;
   logic [7:0]  haddr, t;
   logic [15:0] cfg_devcsr;
   logic [8:0]  tags_outstanding;
   logic [31:0] hwdata, hrdata;
   logic [31:0] q[$];
   logic [7:0]  ra [7] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h10, 8'h18, 8'h40};
   logic [31:0] ex [7] = '{32'h00010001, 32'h01, 32'h5a001000, 32'ha1, 32'h20, 32'h84, 32'h0};
   int          bad_count = 0;
   int          total_checks = 0;
   int          seed = 20580;
   always #2.5 hclk = ~hclk;
   pcc_host pcc_host_inst (.hclk, .hready(hreadyout), .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata, .tmo);
   pcc_config #(.AER_ENABLE(1'b1), .ECRC_CHECK(1'b1), .ECRC_GEN(1'b1), .PORT_NUMBER(8'h5a), .TAGS(64))
      pcc_config_inst (.hclk, .hresetn, .hsel, .haddr, .htrans, .hwrite, .hsize, .hready(hreadyout), .hwdata,
      .hrdata, .hreadyout, .hresp, .cfg_devcsr, .tags_outstanding, .tag_error);
   task automatic test_done;
      if (bad_count == 0 && total_checks > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : test_done
   task automatic cmp(input logic [31:0] g, input logic [31:0] e);
      total_checks++;
      if (g !== e)
      begin
         bad_count++;
         $display("unexpected at %0t: got %h expected %h", $time, g, e);
      end
   endtask : cmp
   task automatic rd(input logic [7:0] a, input logic [31:0] e);
      q.push_back(e);
      pcc_host_inst.xfer(1'b0, a, 32'h0);
   endtask : rd
   task automatic tc(input logic [1:0] op, input logic [7:0] g, input logic c);
      pcc_host_inst.xfer(1'b1, pcc_pkg::ADDR_TAGCMD, {c, 21'h0, op, g});
   endtask : tc
   always @(posedge hclk)
   begin
      if (rdp)
         cmp(hrdata, q.pop_front());
      rdp <= hsel && hreadyout && htrans == pcc_pkg::HTRANS_NONSEQ && !hwrite;
   end
   always @(posedge tmo)
   begin
      bad_count++;
      test_done();
   end
   initial
   begin
      repeat (8) @(posedge hclk);
      hresetn <= 1'b1;
      rd(pcc_pkg::ADDR_DEVCTL, 32'h0);
      foreach (ra[i])
      begin
         pcc_host_inst.xfer(1'b1, ra[i], $random(seed));
         rd(ra[i], ex[i]);
      end
      tc(2'h1, 8'd40, 1'b0);
      rd(pcc_pkg::ADDR_TAGSTAT, 32'h200);
      pcc_host_inst.xfer(1'b1, pcc_pkg::ADDR_DEVCTL, 32'h100);
      #1 cmp({16'h0, cfg_devcsr}, 32'h100);
      t = {3'h0, 5'($random(seed))};
      tc(2'h1, 8'd40, 1'b1);
      tc(2'h1, t, 1'b0);
      rd(pcc_pkg::ADDR_TAGSTAT, 32'h2);
      tc(2'h1, 8'd40, 1'b0);
      tc(2'h1, 8'd64, 1'b0);
      rd(pcc_pkg::ADDR_TAGSTAT, 32'h202);
      tc(2'h3, 8'd40, 1'b1);
      tc(2'h2, t, 1'b0);
      rd(pcc_pkg::ADDR_TAGSTAT, 32'h0);
      tc(2'h1, t, 1'b0);
      @(posedge hclk);
      hresetn <= 1'b0;
      @(posedge hclk);
      hresetn <= 1'b1;
      rd(pcc_pkg::ADDR_DEVCTL, 32'h0);
      rd(pcc_pkg::ADDR_TAGSTAT, 32'h0);
      @(posedge hclk);
      test_done();
   end
endmodule : pcc_config_tb
`default_nettype wire
